// ### bxm_defines.svh
// Offsets, field positions, reset values, strap value and response codes for the bus expansion pin mux
`ifndef BXM_DEFINES_SVH
`define BXM_DEFINES_SVH
`define BXM_OFF_CFG        12'h000
`define BXM_OFF_P5DIR      12'h004
`define BXM_OFF_P4OUT      12'h008
`define BXM_OFF_P5OUT      12'h00C
`define BXM_OFF_P9CTL      12'h010
`define BXM_OFF_PINS       12'h014
`define BXM_OFF_BUSCTL     12'h018
`define BXM_OFF_STATUS     12'h01C
`define BXM_CFG_P4DIR_BIT  0
`define BXM_CFG_WID_LSB    1
`define BXM_CFG_WID_MSB    2
`define BXM_CFG_EXP_BIT    3
`define BXM_CFG_RST        4'h0
`define BXM_P5DIR_RST      8'h00
`define BXM_P9_DIR_LSB     0
`define BXM_P9_OUT_LSB     4
`define BXM_STRAP_SAMPLE   2'h3
`define BXM_RESP_OKAY      2'h0
`define BXM_RESP_SLVERR    2'h2
`endif

// ### bxm_pkg.sv
// Types for the bus expansion pin mux
package bxm_pkg;
    typedef struct packed {
        logic [7:0] o;
        logic [7:0] oe;
    } bxm_pins8_s;
    typedef struct packed {
        logic [3:0] o;
        logic [3:0] oe;
    } bxm_pins4_s;
    typedef struct packed {
        logic       p4Out;
        logic [1:0] width;
        logic       expand;
    } bxm_cfg_s;
    typedef enum logic [2:0] {
        BXM_IDLE = 3'b001,
        BXM_RESP = 3'b010,
        BXM_RDAT = 3'b100
    } bxm_axst_e;
endpackage

// ### bxm_port_lane.sv
// One general-purpose port slice with override by a bus function
`timescale 1ns/1ps
module bxm_port_lane #(
    parameter int W = 8
) (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         rst,
    // Port control
    input  wire logic [W-1:0] gpioOut,
    input  wire logic [W-1:0] gpioDir,
    input  wire logic [W-1:0] busSel,
    input  wire logic [W-1:0] busOut,
    input  wire logic [W-1:0] busOe,
    // Pad side
    output logic      [W-1:0] padO,
    output logic      [W-1:0] padOe
);
    logic [W-1:0] padO_d;
    logic [W-1:0] padOe_d;

    always_comb begin
        for (int i = 0; i < W; i++) begin
            padO_d[i]  = busSel[i] ? busOut[i] : gpioOut[i];
            padOe_d[i] = busSel[i] ? busOe[i]  : gpioDir[i];
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            padO  <= '0;
            padOe <= '0;
        end else begin
            padO  <= padO_d;
            padOe <= padOe_d;
        end
    end
endmodule

// ### bxm_pin_mux.sv
// Function
// RL1 - Port 4 direction is one bit for all eight lines in the config register
// RL2 - In expansion, config register width field sets how much of ports 4/5 serve bus; the code applies it to port 5 only, port 4 is always all bus
// RL3 - Each port 5 line has its own direction bit in the port five direction register
// RL4 - In expansion, port 5 lines drive the upper address lines
// RL5 - In expansion, port 9 bit 0 is read strobe, bit 1 write strobe
// RL6 - ROM-less variant is fixed in expansion mode and has no port 5 direction register
// RL7 - ROM-less variant: port 4 is always the muxed low address/data bus
// RL8 - ROM-less variant: port 9 bits 0/1 always strobes, bits 2/3 stay I/O
// RL9 - With ROM and expansion off, ports 4, 5, 9 are plain I/O
//
// Local design decisions: the AXI4-Lite register port and the address map.
`timescale 1ns/1ps
`include "bxm_defines.svh"
module bxm_pin_mux #(
    parameter bit ROMLESS = 1'b0
) (
    // Clock and reset
    input  wire logic               clk,
    input  wire logic               rst,
    // AXI4-Lite slave
    input  wire logic [11:0]        s_axi_awaddr,
    input  wire logic               s_axi_awvalid,
    output logic                    s_axi_awready,
    input  wire logic [31:0]        s_axi_wdata,
    input  wire logic [3:0]         s_axi_wstrb,
    input  wire logic               s_axi_wvalid,
    output logic                    s_axi_wready,
    output logic [1:0]              s_axi_bresp,
    output logic                    s_axi_bvalid,
    input  wire logic               s_axi_bready,
    input  wire logic [11:0]        s_axi_araddr,
    input  wire logic               s_axi_arvalid,
    output logic                    s_axi_arready,
    output logic [31:0]             s_axi_rdata,
    output logic [1:0]              s_axi_rresp,
    output logic                    s_axi_rvalid,
    input  wire logic               s_axi_rready,
    // Internal bus logic
    input  wire logic [15:0]        busAddr,
    input  wire logic [7:0]         busWrData,
    input  wire logic               busAddrPhase,
    input  wire logic               busWrite,
    input  wire logic               busRdStrobeN,
    input  wire logic               busWrStrobeN,
    output logic [7:0]              busRdData,
    // Straps
    input  wire logic               configStrapZero,
    input  wire logic               configStrapOne,
    // Pads
    input  wire logic [7:0]         portFourIn,
    output bxm_pkg::bxm_pins8_s     portFourLines,
    input  wire logic [7:0]         portFiveIn,
    output bxm_pkg::bxm_pins8_s     portFiveLines,
    input  wire logic [3:0]         portNineIn,
    output bxm_pkg::bxm_pins4_s     portNineLines
);
    import bxm_pkg::*;

    function automatic logic [7:0] upperMask(input logic [1:0] w);
        case (w)
            2'h0:    upperMask = 8'hFF;
            2'h1:    upperMask = 8'h0F;
            2'h2:    upperMask = 8'h03;
            default: upperMask = 8'h00;
        endcase
    endfunction

    // Register state
    bxm_cfg_s   cfg_q, cfg_d;
    logic [7:0] p5Dir_q, p5Dir_d;
    logic [7:0] p4Out_q, p4Out_d;
    logic [7:0] p5Out_q, p5Out_d;
    logic [7:0] p9Ctl_q, p9Ctl_d;
    logic [1:0] strap_q, strap_d;
    logic       strapTaken_q, strapTaken_d;
    // Bus slave state
    bxm_axst_e  wSt_q, wSt_d;
    bxm_axst_e  rSt_q, rSt_d;
    logic       awHeld_q, awHeld_d;
    logic       wHeld_q, wHeld_d;
    logic [11:0] awAddr_q, awAddr_d;
    logic [31:0] wData_q, wData_d;
    logic [3:0]  wStrb_q, wStrb_d;
    logic [1:0]  bresp_q, bresp_d;
    logic [31:0] rdata_q, rdata_d;
    logic [1:0]  rresp_q, rresp_d;
    logic [7:0]  rdBus_q, rdBus_d;

    logic       expandOn;
    logic       p4Bus;
    logic [7:0] p5Sel;
    logic [3:0] p9Sel;
    logic [7:0] p4BusOut, p4BusOe;
    logic [3:0] p9BusOut;
    logic       doWrite;
    logic [31:0] rdMux;
    logic        rdHit;

    // Expansion state: strapped on, register bit, or forced on ROM-less parts
    assign expandOn = ROMLESS | cfg_q.expand | (strap_q == `BXM_STRAP_SAMPLE); // RL6
    assign p4Bus    = ROMLESS | expandOn; // RL7 RL9
    assign p5Sel    = expandOn ? (ROMLESS ? 8'hFF : upperMask(cfg_q.width)) : 8'h00; // RL2 RL4 RL9
    assign p9Sel    = expandOn ? 4'h3 : 4'h0; // RL5 RL8 RL9
    assign p4BusOut = busAddrPhase ? busAddr[7:0] : busWrData;
    assign p4BusOe  = {8{busAddrPhase | busWrite}};
    assign p9BusOut = {2'h0, busWrStrobeN, busRdStrobeN};

    bxm_port_lane #(.W(8)) uPort4 (
        .clk     (clk),
        .rst     (rst),
        .gpioOut (p4Out_q),
        .gpioDir ({8{cfg_q.p4Out}}), // RL1
        .busSel  ({8{p4Bus}}),
        .busOut  (p4BusOut),
        .busOe   (p4BusOe),
        .padO    (portFourLines.o),
        .padOe   (portFourLines.oe)
    );

    bxm_port_lane #(.W(8)) uPort5 (
        .clk     (clk),
        .rst     (rst),
        .gpioOut (p5Out_q),
        .gpioDir (ROMLESS ? 8'h00 : p5Dir_q), // RL3 RL6
        .busSel  (p5Sel),
        .busOut  (busAddr[15:8]), // RL4
        .busOe   (8'hFF),
        .padO    (portFiveLines.o),
        .padOe   (portFiveLines.oe)
    );

    bxm_port_lane #(.W(4)) uPort9 (
        .clk     (clk),
        .rst     (rst),
        .gpioOut (p9Ctl_q[`BXM_P9_OUT_LSB +: 4]),
        .gpioDir (p9Ctl_q[`BXM_P9_DIR_LSB +: 4]), // RL8
        .busSel  (p9Sel),
        .busOut  (p9BusOut), // RL5
        .busOe   (4'hF),
        .padO    (portNineLines.o),
        .padOe   (portNineLines.oe)
    );

    assign busRdData = rdBus_q;

    // Strap capture after reset release
    always_comb begin
        strap_d      = strap_q;
        strapTaken_d = strapTaken_q;
        rdBus_d      = portFourIn;
        if (!strapTaken_q) begin
            strap_d      = {configStrapOne, configStrapZero};
            strapTaken_d = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            strap_q      <= 2'h0;
            strapTaken_q <= 1'b0;
            rdBus_q      <= 8'h00;
        end else begin
            strap_q      <= strap_d;
            strapTaken_q <= strapTaken_d;
            rdBus_q      <= rdBus_d;
        end
    end

    // Register read decode
    always_comb begin
        rdMux = 32'h0000_0000;
        rdHit = 1'b1;
        case (s_axi_araddr)
            `BXM_OFF_CFG:    rdMux = {28'h0, cfg_q.expand, cfg_q.width, cfg_q.p4Out};
            `BXM_OFF_P5DIR:  rdMux = {24'h0, (ROMLESS ? 8'h00 : p5Dir_q)};
            `BXM_OFF_P4OUT:  rdMux = {24'h0, p4Out_q};
            `BXM_OFF_P5OUT:  rdMux = {24'h0, p5Out_q};
            `BXM_OFF_P9CTL:  rdMux = {24'h0, p9Ctl_q};
            `BXM_OFF_PINS:   rdMux = {12'h0, portNineIn, portFiveIn, portFourIn};
            `BXM_OFF_STATUS: rdMux = {28'h0, ROMLESS, strap_q, expandOn};
            default:         rdHit = 1'b0;
        endcase
    end

    assign doWrite = (wSt_q == BXM_IDLE) && (awHeld_q || s_axi_awvalid)
                     && (wHeld_q || s_axi_wvalid);

    // Bus slave and register next state
    always_comb begin
        logic [11:0] a;
        logic [31:0] d;
        logic [3:0]  s;
        a        = awHeld_q ? awAddr_q : s_axi_awaddr;
        d        = wHeld_q ? wData_q : s_axi_wdata;
        s        = wHeld_q ? wStrb_q : s_axi_wstrb;
        wSt_d    = wSt_q;
        rSt_d    = rSt_q;
        awHeld_d = awHeld_q;
        wHeld_d  = wHeld_q;
        awAddr_d = awAddr_q;
        wData_d  = wData_q;
        wStrb_d  = wStrb_q;
        bresp_d  = bresp_q;
        rdata_d  = rdata_q;
        rresp_d  = rresp_q;
        cfg_d    = cfg_q;
        p5Dir_d  = p5Dir_q;
        p4Out_d  = p4Out_q;
        p5Out_d  = p5Out_q;
        p9Ctl_d  = p9Ctl_q;
        case (wSt_q)
            BXM_IDLE: begin
                if (s_axi_awvalid && !awHeld_q) begin
                    awHeld_d = 1'b1;
                    awAddr_d = s_axi_awaddr;
                end
                if (s_axi_wvalid && !wHeld_q) begin
                    wHeld_d = 1'b1;
                    wData_d = s_axi_wdata;
                    wStrb_d = s_axi_wstrb;
                end
                if (doWrite) begin
                    awHeld_d = 1'b0;
                    wHeld_d  = 1'b0;
                    wSt_d    = BXM_RESP;
                    bresp_d  = `BXM_RESP_OKAY;
                    case (a)
                        `BXM_OFF_CFG: if (s[0]) begin
                            cfg_d.p4Out  = d[`BXM_CFG_P4DIR_BIT]; // RL1
                            cfg_d.width  = d[`BXM_CFG_WID_MSB:`BXM_CFG_WID_LSB]; // RL2
                            cfg_d.expand = d[`BXM_CFG_EXP_BIT];
                        end
                        `BXM_OFF_P5DIR: if (s[0] && !ROMLESS) p5Dir_d = d[7:0]; // RL3
                        `BXM_OFF_P4OUT: if (s[0]) p4Out_d = d[7:0];
                        `BXM_OFF_P5OUT: if (s[0]) p5Out_d = d[7:0];
                        `BXM_OFF_P9CTL: if (s[0]) p9Ctl_d = d[7:0];
                        `BXM_OFF_PINS, `BXM_OFF_STATUS: ;
                        default: bresp_d = `BXM_RESP_SLVERR;
                    endcase
                end
            end
            BXM_RESP: begin
                if (s_axi_bready) wSt_d = BXM_IDLE;
            end
            default: wSt_d = BXM_IDLE;
        endcase
        case (rSt_q)
            BXM_IDLE: begin
                if (s_axi_arvalid) begin
                    rdata_d = rdMux;
                    rresp_d = rdHit ? `BXM_RESP_OKAY : `BXM_RESP_SLVERR;
                    rSt_d   = BXM_RDAT;
                end
            end
            BXM_RDAT: begin
                if (s_axi_rready) rSt_d = BXM_IDLE;
            end
            default: rSt_d = BXM_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            wSt_q    <= BXM_IDLE;
            rSt_q    <= BXM_IDLE;
            awHeld_q <= 1'b0;
            wHeld_q  <= 1'b0;
            awAddr_q <= 12'h000;
            wData_q  <= 32'h0000_0000;
            wStrb_q  <= 4'h0;
            bresp_q  <= `BXM_RESP_OKAY;
            rdata_q  <= 32'h0000_0000;
            rresp_q  <= `BXM_RESP_OKAY;
            cfg_q    <= `BXM_CFG_RST;
            p5Dir_q  <= `BXM_P5DIR_RST;
            p4Out_q  <= 8'h00;
            p5Out_q  <= 8'h00;
            p9Ctl_q  <= 8'h00;
        end else begin
            wSt_q    <= wSt_d;
            rSt_q    <= rSt_d;
            awHeld_q <= awHeld_d;
            wHeld_q  <= wHeld_d;
            awAddr_q <= awAddr_d;
            wData_q  <= wData_d;
            wStrb_q  <= wStrb_d;
            bresp_q  <= bresp_d;
            rdata_q  <= rdata_d;
            rresp_q  <= rresp_d;
            cfg_q    <= cfg_d;
            p5Dir_q  <= p5Dir_d;
            p4Out_q  <= p4Out_d;
            p5Out_q  <= p5Out_d;
            p9Ctl_q  <= p9Ctl_d;
        end
    end

    // Handshake outputs derived from registered state
    assign s_axi_awready = (wSt_q == BXM_IDLE) && !awHeld_q;
    assign s_axi_wready  = (wSt_q == BXM_IDLE) && !wHeld_q;
    assign s_axi_bvalid  = (wSt_q == BXM_RESP);
    assign s_axi_bresp   = bresp_q;
    assign s_axi_arready = (rSt_q == BXM_IDLE);
    assign s_axi_rvalid  = (rSt_q == BXM_RDAT);
    assign s_axi_rdata   = rdata_q;
    assign s_axi_rresp   = rresp_q;
endmodule

// ### bxm_pin_mux_monitor.sv
// Assertion checker for the bus expansion pin mux
`timescale 1ns/1ps
module bxm_pin_mux_monitor #(
    parameter bit ROMLESS = 1'b0
) (
    // Clock and reset
    input wire logic                clk,
    input wire logic                rst,
    // Register read channel
    input wire logic                s_axi_arvalid,
    input wire logic                s_axi_arready,
    input wire logic                s_axi_rvalid,
    input wire logic                s_axi_rready,
    // Internal bus
    input wire logic [15:0]         busAddr,
    input wire logic [7:0]          busWrData,
    input wire logic                busAddrPhase,
    input wire logic                busWrite,
    input wire logic                busRdStrobeN,
    input wire logic                busWrStrobeN,
    input wire logic [7:0]          busRdData,
    // Pads
    input wire logic [7:0]          portFourIn,
    input wire bxm_pkg::bxm_pins8_s portFourLines,
    input wire bxm_pkg::bxm_pins8_s portFiveLines,
    input wire bxm_pkg::bxm_pins4_s portNineLines
);
    import bxm_pkg::*;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    chk_rd_strobe:
        assert property (!rst && ROMLESS |=>
            portNineLines.oe[0] && portNineLines.o[0] == $past(busRdStrobeN))
        else $error("read strobe pin wrong");
    chk_wr_strobe:
        assert property (!rst && ROMLESS |=>
            portNineLines.oe[1] && portNineLines.o[1] == $past(busWrStrobeN))
        else $error("write strobe pin wrong");
    chk_upper_addr:
        assert property (!rst && ROMLESS |=> portFiveLines == {$past(busAddr[15:8]), 8'hFF})
        else $error("upper address lines wrong");
    chk_low_addr:
        assert property (!rst && ROMLESS && busAddrPhase |=>
            portFourLines == {$past(busAddr[7:0]), 8'hFF})
        else $error("low address lines wrong");
    chk_low_data:
        assert property (!rst && ROMLESS && busWrite && !busAddrPhase |=>
            portFourLines.o == $past(busWrData))
        else $error("write data lines wrong");
    chk_low_release:
        assert property (!rst && ROMLESS && !busAddrPhase && !busWrite |=>
            portFourLines.oe == 8'h00)
        else $error("data lines not released");
    chk_read_capture:
        assert property (!rst |=> busRdData == $past(portFourIn))
        else $error("read data capture wrong");
    chk_read_answer:
        assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
        else $error("read answer late");
    chk_read_done:
        assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read answer repeated");
endmodule

bind bxm_pin_mux bxm_pin_mux_monitor #(.ROMLESS(ROMLESS)) i_bxm_pin_mux_monitor (
    .clk, .rst, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .busAddr,
    .busWrData, .busAddrPhase, .busWrite, .busRdStrobeN, .busWrStrobeN, .busRdData,
    .portFourIn, .portFourLines, .portFiveLines, .portNineLines
);

// ### bxm_ext_mem.sv
// External memory on the multiplexed bus of the ROM-less block
`timescale 1ns/1ps
module bxm_ext_mem (
    // Clock
    input wire logic                clk,
    // Pads of the block
    input wire bxm_pkg::bxm_pins8_s lowLines,
    input wire bxm_pkg::bxm_pins8_s highLines,
    input wire bxm_pkg::bxm_pins4_s ctlLines,
    // Resolved level of the low lines
    output logic [7:0]              lowLevel
);
    import bxm_pkg::*;
    logic [7:0] mem [0:65535];
    logic [7:0] lowAddrQ = 8'h00;
    logic [7:0] lastQ = 8'h00;
    // Known contents so a read before any write never shows unknowns
    initial begin
        for (int i = 0; i < 65536; i++) begin
            mem[i] = 8'h00;
        end
    end
    always @(posedge clk) begin
        // Address phase: both strobes idle while the low lines drive
        if (lowLines.oe == 8'hFF && ctlLines.o[1:0] == 2'b11) begin
            lowAddrQ <= lowLines.o;
        end
        if (ctlLines.oe[1] && !ctlLines.o[1]) begin
            mem[{highLines.o, lowAddrQ}] <= lowLines.o;
        end
        lastQ <= lowLevel;
    end
    // Undriven lines toggle so a stale value is never read back
    always_comb begin
        if (ctlLines.oe[0] && !ctlLines.o[0]) begin
            lowLevel = mem[{highLines.o, lowAddrQ}];
        end else if (lowLines.oe == 8'hFF) begin
            lowLevel = lowLines.o;
        end else begin
            lowLevel = ~lastQ;
        end
    end
endmodule

// ### tb_bxm_pin_mux.sv
// Self-checking testbench for the bus expansion pin mux
`timescale 1ns/1ps
`include "bxm_defines.svh"
module tb_bxm_pin_mux;
    import bxm_pkg::*;
    logic        clk = 1'b0;
    logic        rst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic        busAddrPhase, busWrite, busRdStrobeN, busWrStrobeN, strap;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0]  s_axi_wstrb, p9In;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [15:0] busAddr;
    logic [7:0]  busWrData, p4In, p5In, rBusRd, rLevel, p4Rd;
    bxm_pins8_s  p4L, p5L, r4L, r5L;
    bxm_pins4_s  p9L, r9L;
    int          nErrors = 0;
    int          testsRun = 0;
    always #50 clk = ~clk;
    bxm_pin_mux i_bxm_pin_mux (
        .clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .busAddr, .busWrData, .busAddrPhase, .busWrite, .busRdStrobeN, .busWrStrobeN,
        .busRdData(p4Rd), .configStrapZero(strap), .configStrapOne(strap), .portFourIn(p4In),
        .portFourLines(p4L), .portFiveIn(p5In), .portFiveLines(p5L), .portNineIn(p9In),
        .portNineLines(p9L)
    );
    bxm_pin_mux #(.ROMLESS(1'b1)) i_bxm_pin_mux_romless (
        .clk, .rst, .s_axi_awaddr, .s_axi_awvalid(1'b0), .s_axi_awready(), .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid(1'b0), .s_axi_wready(), .s_axi_bresp(), .s_axi_bvalid(),
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid(1'b0), .s_axi_arready(), .s_axi_rdata(),
        .s_axi_rresp(), .s_axi_rvalid(), .s_axi_rready, .busAddr, .busWrData, .busAddrPhase,
        .busWrite, .busRdStrobeN, .busWrStrobeN, .busRdData(rBusRd), .configStrapZero(strap),
        .configStrapOne(strap), .portFourIn(rLevel), .portFourLines(r4L), .portFiveIn(p5In),
        .portFiveLines(r5L), .portNineIn(p9In), .portNineLines(r9L)
    );
    bxm_ext_mem i_bxm_ext_mem (.clk, .lowLines(r4L), .highLines(r5L), .ctlLines(r9L),
        .lowLevel(rLevel));
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        testsRun++;
        if (got !== exp) begin
            nErrors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic settle();
        repeat (3) @(posedge clk);
    endtask
    task automatic axiWr(input logic [11:0] a, input logic [31:0] d);
        logic bDone;
        bDone = 1'b0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!bDone) begin
            @(posedge clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            bDone = s_axi_bvalid;
        end
        s_axi_bready <= 1'b0;
        @(posedge clk);
    endtask
    task automatic axiRd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
        logic rDone;
        rDone = 1'b0;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        while (!rDone) begin
            @(posedge clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            rDone = s_axi_rvalid;
            d = s_axi_rdata;
            r = s_axi_rresp;
        end
        s_axi_rready <= 1'b0;
        @(posedge clk);
    endtask
    task automatic regScenario();
        logic [31:0] d;
        logic [1:0] r;
        axiRd(`BXM_OFF_CFG, d, r);
        check(d, `BXM_CFG_RST);
        axiRd(`BXM_OFF_STATUS, d, r);
        check(d, 32'h0);
        axiRd(`BXM_OFF_BUSCTL, d, r);
        check(32'(r), 32'(`BXM_RESP_SLVERR));
    endtask
    task automatic expandScenario();
        logic [7:0] mt [4] = '{8'hFF, 8'h0F, 8'h03, 8'h00};
        busAddr <= 16'hBEEF;
        busAddrPhase <= 1'b1;
        busRdStrobeN <= 1'b0;
        for (int w = 0; w < 4; w++) begin
            axiWr(`BXM_OFF_CFG, 32'((1 << `BXM_CFG_EXP_BIT) | (w << `BXM_CFG_WID_LSB)));
            settle();
            check(32'(p5L.oe), 32'(mt[w]));
            check(32'(p5L.o & mt[w]), 32'(8'hBE & mt[w]));
            check(32'({p9L.oe[1:0], p9L.o[1:0]}), 32'hE);
            check(32'(p4L), 32'hEFFF);
        end
        busRdStrobeN <= 1'b1;
        busAddrPhase <= 1'b0;
        axiWr(`BXM_OFF_CFG, 32'h0);
        settle();
        check(32'({p4L.oe, p5L.oe, p9L.oe}), 32'h0);
    endtask
    task automatic gpioScenario();
        logic [31:0] d;
        logic [1:0] r;
        p4In <= 8'h3C;
        p5In <= 8'h96;
        p9In <= 4'h5;
        axiWr(`BXM_OFF_P4OUT, 32'hA5);
        axiWr(`BXM_OFF_CFG, 32'h1);
        axiWr(`BXM_OFF_P5DIR, 32'h5A);
        axiWr(`BXM_OFF_P5OUT, 32'hFF);
        axiWr(`BXM_OFF_P9CTL, 32'hAC);
        settle();
        check(32'(p4L), 32'hA5FF);
        check(32'({p5L.oe, p5L.o & 8'h5A}), 32'h5A5A);
        check(32'({p9L.oe, p9L.o & 4'hC}), 32'hC8);
        axiRd(`BXM_OFF_PINS, d, r);
        check(d, 32'h5963C);
        check(32'(p4Rd), 32'h3C);
    endtask
    task automatic romlessScenario();
        busAddr <= 16'h1234;
        busAddrPhase <= 1'b1;
        settle();
        check(32'({r4L, r5L}), 32'h34FF12FF);
        check(32'(r9L.oe), 32'h3);
        busAddrPhase <= 1'b0;
        busWrite <= 1'b1;
        busWrData <= 8'h5A;
        busWrStrobeN <= 1'b0;
        settle();
        check(32'(r4L), 32'h5AFF);
        busWrite <= 1'b0;
        busWrStrobeN <= 1'b1;
        busAddrPhase <= 1'b1;
        settle();
        busAddrPhase <= 1'b0;
        busRdStrobeN <= 1'b0;
        settle();
        check(32'({r4L.oe, rBusRd}), 32'h005A);
        busRdStrobeN <= 1'b1;
    endtask
    task automatic tally_and_finish();
        if (nErrors == 0 && testsRun > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    initial begin
        repeat (5000) @(posedge clk);
        nErrors++;
        tally_and_finish();
    end
    initial begin
        {rst, busRdStrobeN, busWrStrobeN, s_axi_wstrb} = 7'h7F;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, busAddr, busWrData} = '0;
        {busAddrPhase, busWrite, strap, p4In, p5In, p9In} = '0;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        regScenario();
        expandScenario();
        gpioScenario();
        romlessScenario();
        tally_and_finish();
    end
endmodule
